// *** crl_pkg.sv ***
// Constants shared by the calibration register loader files
package crl_pkg;
  localparam int unsigned WORD_W         = 16;
  localparam int unsigned BYTE_W         = 8;
  localparam int unsigned ADDR_W         = 10;
  localparam int unsigned IDX_W          = 8;
  localparam int unsigned MEM_BYTES      = 768;
  localparam int unsigned PAGE_BYTES     = 64;
  localparam int unsigned PAGE_COUNT     = 12;
  localparam int unsigned PAGE_W         = 4;
  localparam int unsigned ICR_COUNT      = 5;
  localparam int unsigned SEL_W          = 3;
  localparam int unsigned ICR_ADDR_W     = 4;

  // Fixed word locations
  localparam logic [9:0] CONFIG_ADDR     = 10'h160;
  localparam logic [9:0] RSVD_A_ADDR     = 10'h162;
  localparam logic [9:0] OTC_ADDR        = 10'h164;
  localparam logic [9:0] RSVD_B_ADDR     = 10'h166;
  localparam logic [9:0] STC_ADDR        = 10'h168;
  localparam logic [9:0] PROT_ADDR       = 10'h16A;
  localparam logic [9:0] USER_FIRST      = 10'h16C;
  localparam logic [9:0] USER_LAST       = 10'h19F;

  // Trim table layout
  localparam logic [9:0] OFF_TBL_BASE    = 10'h000;
  localparam logic [9:0] SPAN_LOW_BASE   = 10'h200;
  localparam logic [9:0] SPAN_HIGH_BASE  = 10'h1A0;
  localparam logic [7:0] IDX_SPLIT       = 8'h80;
  localparam logic [7:0] IDX_TOP         = 8'hAF;

  // Protection byte codes
  localparam logic [7:0] PROT_LOCKED     = 8'hFF;
  localparam logic [7:0] PROT_OPEN       = 8'h00;
  localparam logic [7:0] ERASED_BYTE     = 8'hFF;

  // Word selects, also the serial load target addresses
  localparam logic [2:0] SEL_CONFIG      = 3'h0;
  localparam logic [2:0] SEL_OTC         = 3'h1;
  localparam logic [2:0] SEL_STC         = 3'h2;
  localparam logic [2:0] SEL_OFF         = 3'h3;
  localparam logic [2:0] SEL_SPAN        = 3'h4;
  localparam logic [15:0] ICR_RESET      = 16'h0000;

  // Temperature index period
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned IDX_PERIOD_NS  = 1_000_000;
  localparam int unsigned IDX_PERIOD_CYC = IDX_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TMR_W          = 17;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LO   = 4'b0010,
    ST_HI   = 4'b0100,
    ST_NEXT = 4'b1000
  } crl_state_t;
endpackage : crl_pkg

// *** crl_idx_if.sv ***
// Temperature index and table pointer signals between loader modules
`timescale 1ns/1ps
`default_nettype none
interface crl_idx_if;
  import crl_pkg::*;
  logic [IDX_W-1:0]  temp_index;
  logic              tick;
  logic [ADDR_W-1:0] off_addr;
  logic [ADDR_W-1:0] span_addr;

  modport timer  (output temp_index, output tick);
  modport mapper (input temp_index, output off_addr, output span_addr);
  modport loader (input temp_index, input tick,
                  input off_addr, input span_addr);
endinterface : crl_idx_if
`default_nettype wire

// *** crl_index_timer.sv ***
// Millisecond timer that samples the temperature converter output
`timescale 1ns/1ps
`default_nettype none
module crl_index_timer #(
  parameter int unsigned PERIOD_CYC = crl_pkg::IDX_PERIOD_CYC
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic [crl_pkg::IDX_W-1:0] i_temp_code,
  crl_idx_if.timer                   idx
);
  import crl_pkg::*;

  logic [TMR_W-1:0] count_q;
  logic [IDX_W-1:0] index_q;
  logic             tick_q;
  logic             wrap;

  assign wrap = (count_q == TMR_W'(PERIOD_CYC - 1));

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count_q <= '0;
    end else if (wrap) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + TMR_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      index_q <= '0;
      tick_q  <= 1'b0;
    end else begin
      tick_q <= wrap;
      if (wrap) begin
        index_q <= i_temp_code; // R13
      end
    end
  end

  assign idx.temp_index = index_q;
  assign idx.tick       = tick_q;
endmodule : crl_index_timer
`default_nettype wire

// *** crl_table_map.sv ***
// Maps the temperature index onto trim table byte addresses
`timescale 1ns/1ps
`default_nettype none
module crl_table_map (
  crl_idx_if.mapper idx
);
  import crl_pkg::*;

  logic [IDX_W-1:0]  clamped;
  logic [IDX_W-1:0]  high_part;
  logic [ADDR_W-1:0] span_low;
  logic [ADDR_W-1:0] span_high;

  // Index 00 is already the floor, so only the top needs clamping
  assign clamped   = (idx.temp_index > IDX_TOP) ? IDX_TOP
                                                : idx.temp_index; // R14 R18
  assign high_part = clamped - IDX_SPLIT;
  assign span_low  = SPAN_LOW_BASE + {1'b0, clamped, 1'b0};
  assign span_high = SPAN_HIGH_BASE + {1'b0, high_part, 1'b0};

  assign idx.off_addr  = OFF_TBL_BASE + {1'b0, clamped, 1'b0}; // R08
  assign idx.span_addr = (clamped < IDX_SPLIT) ? span_low
                                               : span_high; // R09
endmodule : crl_table_map
`default_nettype wire

// *** crl_loader.sv ***
// Calibration register loader with byte-wide nonvolatile store
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R01: Five 16-bit calibration registers, filled from memory or serial loads.
// R02: Protection byte all ones and unlock low selects normal operation.
// R03: After reset, normal mode refreshes fixed words and indexed trims.
// R04: Normal mode repeats the five-word refresh on every 1ms tick.
// R05: Protection byte zero or unlock high enables serial register loads.
// R06: Memory holds 768 bytes as 12 pages of 64 bytes.
// R07: Any single page can be erased on its own.
// R08: Offset trim table spans 000 to 15F, two bytes per index.
// R09: Span trim table: indices below 80 at 200, above at 1A0.
// R10: Words pair even low byte with next address high byte.
// R11: The 52 user bytes are plain bytes, never loaded into registers.
// R12: Config at 160, offset tempco 164, span tempco 168; 162, 166 reserved.
// R13: Temperature converter output stored into index register every 1ms.
// R14: Index selects a byte pair; AF through FF pick the last entry.
// R15: Trim entries chosen from the current temperature index register.
// R16: Host keeps factory oscillator bits; all other bytes ship erased.
// R17: Protection byte zero turns the data pin into a serial input.
// R18: Index floor is entry 00; above top clamps with no wraparound.
// R19: Host fills data holding register, sets target, then issues load.
// R20: Calibration mode never lets periodic refresh overwrite loaded values.
module crl_loader #(
  parameter int unsigned IDX_PERIOD = crl_pkg::IDX_PERIOD_CYC
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_unlock,
  input  wire logic [crl_pkg::IDX_W-1:0]     i_temp_code,
  input  wire logic                          i_load_register_command,
  input  wire logic [crl_pkg::ICR_ADDR_W-1:0] i_target_register_address,
  input  wire logic [crl_pkg::WORD_W-1:0]    i_data_holding_register,
  input  wire logic                          i_mem_write,
  input  wire logic [crl_pkg::ADDR_W-1:0]    i_mem_addr,
  input  wire logic [crl_pkg::BYTE_W-1:0]    i_mem_wdata,
  input  wire logic                          i_page_erase,
  input  wire logic [crl_pkg::PAGE_W-1:0]    i_page,
  output logic [crl_pkg::WORD_W-1:0]         o_configuration_word,
  output logic [crl_pkg::WORD_W-1:0]         o_offset_tempco_register,
  output logic [crl_pkg::WORD_W-1:0]         o_span_tempco_register,
  output logic [crl_pkg::WORD_W-1:0]         o_offset_trim_register,
  output logic [crl_pkg::WORD_W-1:0]         o_span_trim_register,
  output logic [crl_pkg::IDX_W-1:0]          o_temp_index,
  output logic [crl_pkg::BYTE_W-1:0]         o_mem_rdata,
  output logic                               o_calibration_mode,
  output logic                               o_single_data_pin_in_en,
  output logic                               o_refresh_busy
);
  import crl_pkg::*;

  crl_idx_if idx ();

  crl_index_timer #(
    .PERIOD_CYC (IDX_PERIOD)
  ) u_timer (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_temp_code (i_temp_code),
    .idx         (idx.timer)
  );

  crl_table_map u_map (
    .idx (idx.mapper)
  );

  // Nonvolatile store; contents survive reset on purpose
  logic [BYTE_W-1:0] mem_q [MEM_BYTES]; // R06

  logic [WORD_W-1:0] icr_q [ICR_COUNT];
  logic              calib_q;
  logic              mode_valid_q;
  logic              boot_pend_q;
  logic              tick_pend_q;
  logic [IDX_W-1:0]  index_q;
  logic [BYTE_W-1:0] rdata_q;
  logic [BYTE_W-1:0] lo_q;
  logic [ADDR_W-1:0] fetch_addr_q;
  logic [ADDR_W-1:0] fetch_addr_d;
  logic [SEL_W-1:0]  sel_q;
  logic [SEL_W-1:0]  sel_d;
  crl_state_t        state_q;
  crl_state_t        state_d;
  logic [BYTE_W-1:0] prot_byte;
  logic              unlocked;
  logic              start;
  logic              word_done;
  logic [WORD_W-1:0] fetched;
  logic              host_ok;
  logic [ADDR_W-1:0] page_base;
  logic [ADDR_W-1:0] off_addr_q;
  logic [ADDR_W-1:0] span_addr_q;
  logic              busy_q;
  logic              erase_hit;
  logic              write_hit;

  // Mode decode from the live protection byte and unlock pin
  assign prot_byte = mem_q[PROT_ADDR];
  assign unlocked  = (prot_byte == PROT_OPEN) || i_unlock; // R05
  // Protection codes other than 00 or FF are treated as locked

  // Registered, so the mode follows the pin one cycle later and can still flip mid-word
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      calib_q <= 1'b0;
    end else begin
      calib_q <= unlocked; // R02 R05
    end
  end

  // Mode is only trusted from the second edge after reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_valid_q <= 1'b0;
    end else begin
      mode_valid_q <= 1'b1;
    end
  end

  // Host requests are ignored until the mode is known
  assign host_ok = mode_valid_q && calib_q;

  // Refresh requests: power-up once, then every index tick
  assign start = (state_q == ST_IDLE) && mode_valid_q && !calib_q
                 && (boot_pend_q || tick_pend_q);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      boot_pend_q <= 1'b1; // R03
    end else if (start) begin
      boot_pend_q <= 1'b0;
    end
  end

  // A tick landing with the start is kept, set wins
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tick_pend_q <= 1'b0;
    end else if (idx.tick) begin
      tick_pend_q <= 1'b1; // R04
    end else if (start) begin
      tick_pend_q <= 1'b0;
    end
  end

  // Copy of the index register for the output pin
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      index_q <= '0;
    end else begin
      index_q <= idx.temp_index; // R13
    end
  end

  // Trim addresses frozen at the start so both trims share one index
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      off_addr_q  <= OFF_TBL_BASE;
      span_addr_q <= SPAN_LOW_BASE;
    end else if (start) begin
      off_addr_q  <= idx.off_addr; // R15
      span_addr_q <= idx.span_addr; // R15
    end
  end

  function automatic logic [ADDR_W-1:0] word_addr(
    input logic [SEL_W-1:0]  sel,
    input logic [ADDR_W-1:0] off_a,
    input logic [ADDR_W-1:0] span_a
  );
    logic [ADDR_W-1:0] a;
    a = CONFIG_ADDR;
    case (sel)
      SEL_CONFIG: a = CONFIG_ADDR; // R12
      SEL_OTC:    a = OTC_ADDR; // R12
      SEL_STC:    a = STC_ADDR; // R12
      SEL_OFF:    a = off_a; // R08
      SEL_SPAN:   a = span_a; // R09
      default:    a = CONFIG_ADDR;
    endcase
    return a;
  endfunction

  assign fetched   = {mem_q[fetch_addr_q], lo_q}; // R10
  assign word_done = (state_q == ST_HI);

  always_comb begin
    state_d      = state_q;
    sel_d        = sel_q;
    fetch_addr_d = fetch_addr_q;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d      = ST_LO;
          sel_d        = SEL_CONFIG;
          fetch_addr_d = CONFIG_ADDR; // R03
        end
      end
      ST_LO: begin
        state_d      = ST_HI;
        fetch_addr_d = fetch_addr_q + ADDR_W'(1);
      end
      ST_HI: begin
        state_d = ST_NEXT;
      end
      ST_NEXT: begin
        if (sel_q == SEL_SPAN) begin
          state_d = ST_IDLE;
        end else begin
          state_d      = ST_LO;
          sel_d        = sel_q + SEL_W'(1);
          fetch_addr_d = word_addr(sel_q + SEL_W'(1),
                                   off_addr_q, span_addr_q);
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Which of the five words is being fetched
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sel_q <= SEL_CONFIG;
    end else begin
      sel_q <= sel_d;
    end
  end

  // Byte address walks the low then the high byte of each word
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fetch_addr_q <= CONFIG_ADDR;
    end else begin
      fetch_addr_q <= fetch_addr_d;
    end
  end

  // Low byte held until the high byte arrives
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lo_q <= '0;
    end else if (state_q == ST_LO) begin
      lo_q <= mem_q[fetch_addr_q]; // R10
    end
  end

  // Busy taken from the next state so the pin comes from a flop
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_d != ST_IDLE);
    end
  end

  // One write port per register. A refresh write and a host load
  // never meet: one needs normal mode, the other calibration mode
  generate
    for (genvar r = 0; r < ICR_COUNT; r++) begin : g_icr
      logic refresh_hit;
      logic host_hit;

      assign refresh_hit = word_done && !calib_q
                           && (sel_q == SEL_W'(r));
      assign host_hit    = host_ok && i_load_register_command
                           && (i_target_register_address
                               == ICR_ADDR_W'(r)); // R05

      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          icr_q[r] <= ICR_RESET;
        end else if (refresh_hit) begin
          icr_q[r] <= fetched; // R01 R03 R20
        end else if (host_hit) begin
          icr_q[r] <= i_data_holding_register; // R01 R05
        end
      end
    end
  endgenerate

  // Erase and byte writes only while calibration is open
  assign page_base = ADDR_W'(i_page) * ADDR_W'(PAGE_BYTES);
  assign erase_hit = host_ok && i_page_erase
                     && (i_page < PAGE_W'(PAGE_COUNT));
  assign write_hit = host_ok && i_mem_write
                     && (i_mem_addr < ADDR_W'(MEM_BYTES));

  // Erase wins over a byte write in the same cycle
  always_ff @(posedge i_clk) begin
    if (erase_hit) begin
      for (int b = 0; b < PAGE_BYTES; b++) begin
        mem_q[page_base + ADDR_W'(b)] <= ERASED_BYTE; // R07
      end
    end else if (write_hit) begin
      mem_q[i_mem_addr] <= i_mem_wdata; // R11
    end
  end

  // Byte readback, user bytes included, one cycle after the address
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q <= '0;
    end else if (i_mem_addr < ADDR_W'(MEM_BYTES)) begin
      rdata_q <= mem_q[i_mem_addr]; // R11
    end else begin
      rdata_q <= '0;
    end
  end

  assign o_configuration_word     = icr_q[SEL_CONFIG];
  assign o_offset_tempco_register = icr_q[SEL_OTC];
  assign o_span_tempco_register   = icr_q[SEL_STC];
  assign o_offset_trim_register   = icr_q[SEL_OFF];
  assign o_span_trim_register     = icr_q[SEL_SPAN];
  assign o_temp_index             = index_q;
  assign o_mem_rdata              = rdata_q;
  assign o_calibration_mode       = calib_q;
  assign o_single_data_pin_in_en  = calib_q; // R17
  assign o_refresh_busy           = busy_q;
endmodule : crl_loader
`default_nettype wire

// *** crl_loader_monitor.sv ***
// Port-level checker for the calibration register loader
`timescale 1ns/1ps
`default_nettype none
module crl_loader_monitor
  import crl_pkg::*;
#(
  parameter int unsigned IDX_PERIOD = IDX_PERIOD_CYC
) (
  input wire logic                     i_clk,
  input wire logic                     i_rst,
  input wire logic                     i_unlock,
  input wire logic                     i_load_register_command,
  input wire logic [ICR_ADDR_W-1:0]    i_target_register_address,
  input wire logic [WORD_W-1:0]        i_data_holding_register,
  input wire logic [WORD_W-1:0]        o_configuration_word,
  input wire logic [WORD_W-1:0]        o_offset_trim_register,
  input wire logic [WORD_W-1:0]        o_span_trim_register,
  input wire logic [IDX_W-1:0]         o_temp_index,
  input wire logic                     o_calibration_mode,
  input wire logic                     o_single_data_pin_in_en,
  input wire logic                     o_refresh_busy
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  AST_LOAD_CFG: assert property (
    o_calibration_mode && i_load_register_command &&
    i_target_register_address == {1'b0, SEL_CONFIG}
    |=> o_configuration_word == $past(i_data_holding_register))
    else $error("configuration load lost");
  AST_LOAD_OFF: assert property (
    o_calibration_mode && i_load_register_command &&
    i_target_register_address == {1'b0, SEL_OFF}
    |=> o_offset_trim_register == $past(i_data_holding_register))
    else $error("offset trim load lost");
  AST_LOAD_SPAN: assert property (
    o_calibration_mode && i_load_register_command &&
    i_target_register_address == {1'b0, SEL_SPAN}
    |=> o_span_trim_register == $past(i_data_holding_register))
    else $error("span trim load lost");
  AST_CAL_HOLD: assert property (
    o_calibration_mode && !i_load_register_command
    |=> $stable(o_offset_trim_register) && $stable(o_span_trim_register)
        && $stable(o_configuration_word))
    else $error("register changed in calibration without load");
  AST_PIN_EN: assert property (
    o_single_data_pin_in_en == o_calibration_mode)
    else $error("data pin input enable differs from mode");
  AST_UNLOCK: assert property (
    i_unlock [*3] |=> o_calibration_mode)
    else $error("unlock did not give calibration mode");
  AST_REFRESH_NORMAL: assert property (
    $rose(o_refresh_busy) |-> !$past(o_calibration_mode))
    else $error("refresh started in calibration mode");
  AST_BUSY_BOUND: assert property (
    $rose(o_refresh_busy) |-> ##[4:30] !o_refresh_busy)
    else $error("refresh did not finish in time");
  AST_RESET_ZERO: assert property (
    $fell(i_rst) |-> o_configuration_word == ICR_RESET &&
    o_temp_index == 8'h00 && !o_refresh_busy)
    else $error("outputs not cleared by reset");
endmodule // crl_loader_monitor

bind crl_loader crl_loader_monitor #(
  .IDX_PERIOD (IDX_PERIOD)
) i_mon (
  .i_clk                     (i_clk),
  .i_rst                     (i_rst),
  .i_unlock                  (i_unlock),
  .i_load_register_command   (i_load_register_command),
  .i_target_register_address (i_target_register_address),
  .i_data_holding_register   (i_data_holding_register),
  .o_configuration_word      (o_configuration_word),
  .o_offset_trim_register    (o_offset_trim_register),
  .o_span_trim_register      (o_span_trim_register),
  .o_temp_index              (o_temp_index),
  .o_calibration_mode        (o_calibration_mode),
  .o_single_data_pin_in_en   (o_single_data_pin_in_en),
  .o_refresh_busy            (o_refresh_busy)
);
`default_nettype wire

// *** crl_host.sv ***
// Host calibration system model issuing decoded loads and memory requests
`timescale 1ns/1ps
`default_nettype none
module crl_host (
  input  wire logic        i_clk,
  input  wire logic [7:0]  i_rdata,
  output logic             o_load,
  output logic [3:0]       o_target,
  output logic [15:0]      o_data,
  output logic             o_wr,
  output logic [9:0]       o_addr,
  output logic [7:0]       o_wdata,
  output logic             o_erase,
  output logic [3:0]       o_page
);
  initial begin
    {o_load, o_wr, o_erase} = 3'h0;
    {o_target, o_page, o_addr, o_wdata, o_data} = '0;
  end
  // Data and target change on the same edge as the strobe
  task automatic load(input logic [3:0] t, input logic [15:0] d);
    @(posedge i_clk);
    o_data   <= d;
    o_target <= t;
    o_load   <= 1'b1;
    @(posedge i_clk);
    o_load <= 1'b0;
    o_data <= ~d; // Stale data must not look valid
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] b);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= b;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_wdata <= ~b;
  endtask
  task automatic erase(input logic [3:0] p);
    @(posedge i_clk);
    o_page  <= p;
    o_erase <= 1'b1;
    @(posedge i_clk);
    o_erase <= 1'b0;
    o_page  <= ~p;
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] b);
    @(posedge i_clk);
    o_addr <= a;
    @(posedge i_clk);
    #1 b = i_rdata;
  endtask
endmodule // crl_host
`default_nettype wire

// *** test_calibration_register_loader.sv ***
// Self-checking bench for the calibration register loader
`timescale 1ns/1ps
`default_nettype none
module test_calibration_register_loader;
  import crl_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        unlock = 1'b1;
  logic [7:0]  temp = 8'h00;
  logic        ld, wr, er, cal, pin, busy;
  logic [3:0]  tgt, pg;
  logic [15:0] data_holding_register, cfg, otc, stc, off, spn;
  logic [9:0]  ad;
  logic [7:0]  wd, rd, idx, b;
  logic [79:0] allw;
  logic [7:0]  tl [3] = '{8'h10, 8'h90, 8'hC3};
  int          fails = 0;
  int          tests_run = 0;

  assign allw = {spn, off, stc, otc, cfg};
  always #10 clk = ~clk;

  crl_host h (.i_clk(clk), .i_rdata(rd), .o_load(ld), .o_target(tgt),
    .o_data(data_holding_register), .o_wr(wr), .o_addr(ad), .o_wdata(wd), .o_erase(er),
    .o_page(pg));
  crl_loader #(.IDX_PERIOD(40)) i_dut (.i_clk(clk), .i_rst(rst),
    .i_unlock(unlock), .i_temp_code(temp), .i_load_register_command(ld),
    .i_target_register_address(tgt), .i_data_holding_register(data_holding_register),
    .i_mem_write(wr), .i_mem_addr(ad), .i_mem_wdata(wd),
    .i_page_erase(er), .i_page(pg), .o_configuration_word(cfg),
    .o_offset_tempco_register(otc), .o_span_tempco_register(stc),
    .o_offset_trim_register(off), .o_span_trim_register(spn),
    .o_temp_index(idx), .o_mem_rdata(rd), .o_calibration_mode(cal),
    .o_single_data_pin_in_en(pin), .o_refresh_busy(busy));

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, s);
    tests_run++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      fails++;
    end
  endtask
  task automatic wb(input logic l);
    int n;
    n = 0;
    while (busy !== l) begin
      @(posedge clk);
      #1 n++;
      if (n > 300) begin
        chk("refresh busy", {15'h0000, l}, {15'h0000, busy});
        conclude();
      end
    end
  endtask
  task automatic rb(input logic [9:0] a, input logic [7:0] e);
    h.rd(a, b);
    chk("byte", {8'h00, e}, {8'h00, b});
  endtask
  // Word pairs: low byte at the even address
  task automatic ww(input logic [9:0] a, input logic [15:0] w);
    h.wr(a, w[7:0]);
    h.wr(a + 10'h001, w[15:8]);
  endtask
  // Top three bits kept set so oscillator trim is preserved
  function automatic logic [15:0] fw(input logic [9:0] a);
    return {6'h38, a};
  endfunction
  function automatic logic [7:0] cl(input logic [7:0] t);
    return (t > IDX_TOP) ? IDX_TOP : t;
  endfunction
  function automatic logic [9:0] oa(input logic [7:0] t);
    return {1'b0, cl(t), 1'b0};
  endfunction
  function automatic logic [9:0] sa(input logic [7:0] t);
    logic [7:0] c;
    c = cl(t);
    if (c < IDX_SPLIT)
      return SPAN_LOW_BASE + {1'b0, c, 1'b0};
    return SPAN_HIGH_BASE + {1'b0, c - IDX_SPLIT, 1'b0};
  endfunction
  task automatic check_all(input logic [9:0] o, s);
    chk("config", fw(CONFIG_ADDR), cfg);
    chk("offset tempco", fw(OTC_ADDR), otc);
    chk("span tempco", fw(STC_ADDR), stc);
    chk("offset trim", (o === 10'h3FF) ? 16'hFFFF : fw(o), off);
    chk("span trim", (s === 10'h3FF) ? 16'hFFFF : fw(s), spn);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("reset word", ICR_RESET, off);
    chk("mode", 16'h0001, {15'h0000, cal});
    for (int p = 0; p < 12; p++) h.erase(4'(p));
    h.wr(10'h040, 8'h12);
    h.erase(4'h0);
    rb(10'h040, 8'h12);
    rb(10'h000, ERASED_BYTE);
    rb(10'h2FF, ERASED_BYTE);
    rb(10'h300, 8'h00);
    ww(CONFIG_ADDR, fw(CONFIG_ADDR));
    ww(OTC_ADDR, fw(OTC_ADDR));
    ww(STC_ADDR, fw(STC_ADDR));
    ww(RSVD_A_ADDR, 16'h0BAD);
    h.wr(USER_FIRST, 8'h77);
    h.wr(PROT_ADDR, PROT_LOCKED);
    foreach (tl[i]) begin
      ww(oa(tl[i]), fw(oa(tl[i])));
      ww(sa(tl[i]), fw(sa(tl[i])));
    end
    $display("Test memory done");
    for (int s = 0; s < 5; s++) begin
      h.load(4'(s), 16'h1000 + 16'(s));
      @(posedge clk);
      #1 chk("load", 16'h1000 + 16'(s), allw[s*16 +: 16]);
    end
    @(posedge clk);
    temp <= 8'h33;
    h.load(4'h5, 16'hDEAD);
    repeat (100) @(posedge clk);
    #1 chk("bad target", 16'h1003, off);
    chk("index", 16'h0033, {8'h00, idx});
    $display("Test serial loads done");
    @(posedge clk);
    unlock <= 1'b0;
    foreach (tl[i]) begin
      @(posedge clk);
      temp <= tl[i];
      // Past one full tick, so any refresh seen uses the new index
      repeat (60) @(posedge clk);
      wb(1'b1);
      wb(1'b0);
      chk("normal mode", 16'h0000, {15'h0000, cal});
      chk("index", {8'h00, tl[i]}, {8'h00, idx});
      check_all(oa(tl[i]), sa(tl[i]));
    end
    h.wr(USER_FIRST, 8'h00);
    rb(USER_FIRST, 8'h77);
    $display("Test refresh done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wb(1'b1);
    wb(1'b0);
    check_all(10'h3FF, 10'h3FF);
    $display("Test boot done");
    @(posedge clk);
    unlock <= 1'b1;
    repeat (4) @(posedge clk);
    h.wr(PROT_ADDR, PROT_OPEN);
    unlock <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("open pin", 16'h0001, {15'h0000, pin});
    h.load({1'b0, SEL_OFF}, 16'hBEEF);
    @(posedge clk);
    #1 chk("open load", 16'hBEEF, off);
    $display("Test open protection done");
    conclude();
  end
endmodule // test_calibration_register_loader
`default_nettype wire
